// file: rtl/fcd_fifo.sv
// fcd_fifo: show-ahead fifo with valid/ready on both sides
// assumes: synchronous active-high reset; output word valid while out_valid_o

module fcd_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // fill side
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  // drain side
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i,
  // state
  output logic empty_o,
  output logic full_o
);

  localparam int AW = $clog2(DEPTH);

  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW-1:0] rd_ptr_next;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  assign full_o = (count_reg == (AW + 1)'(DEPTH));
  assign empty_o = (count_reg == '0);
  assign in_ready_o = !full_o;
  assign out_valid_o = !empty_o;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign rd_ptr_next = pop ? ptr_inc(rd_ptr_reg) : rd_ptr_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= ptr_inc(wr_ptr_reg);
      end
      rd_ptr_reg <= rd_ptr_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_reg <= '0;
    end else if (push && !pop) begin
      count_reg <= count_reg + 1'b1;
    end else if (pop && !push) begin
      count_reg <= count_reg - 1'b1;
    end
  end

  fcd_mem #(
    .WIDTH(WIDTH),
    .DEPTH(DEPTH)
  ) u_mem (
    .clk_i(clk_i),
    .we_i(push),
    .wr_addr_i(wr_ptr_reg),
    .wr_data_i(in_data_i),
    .rd_addr_i(rd_ptr_next),
    .rd_data_o(out_data_o)
  );

endmodule

// file: rtl/fcd_mem.sv
// fcd_mem: small dual-port word store with registered, write-first read
// assumes: single clock; one write and one read address per cycle

module fcd_mem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // clock
  input wire logic clk_i,
  // write port
  input wire logic we_i,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr_i,
  input wire logic [WIDTH-1:0] wr_data_i,
  // read port
  input wire logic [$clog2(DEPTH)-1:0] rd_addr_i,
  output logic [WIDTH-1:0] rd_data_o
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  // bypass keeps a word written into an empty fifo visible next cycle
  always_ff @(posedge clk_i) begin
    if (we_i && (wr_addr_i == rd_addr_i)) begin
      rd_data_o <= wr_data_i;
    end else begin
      rd_data_o <= mem[rd_addr_i];
    end
  end

endmodule

// file: rtl/fcd_pkg.sv
// fcd_pkg: constants, field layout and types of the frame control decoder
// assumes: one 25 mhz master clock; all counts are in master-clock periods

package fcd_pkg;

  // =====================================================================
  // clock and word widths
  localparam int MCLK_HZ = 25_000_000;
  localparam int CNT_W = 10;
  localparam int PHASE_W = 8;
  localparam int WORD_W = 16;
  localparam int DAC_W = 14;
  localparam int FIFO_DEPTH = 8;

  // =====================================================================
  // frame timing in master-clock periods
  localparam logic [CNT_W-1:0] BASE_FRAME = 10'h200;
  localparam logic [CNT_W-1:0] SEC_POS = 10'h100;
  localparam logic [CNT_W-1:0] SYNC_CYC = 10'h004;
  localparam logic [1:0] DIV_SAMPLE = 2'h2;
  localparam logic [1:0] DIV_LAST = 2'h3;
  localparam logic [3:0] LAST_BIT = 4'hF;

  // =====================================================================
  // wishbone register map (byte addresses)
  localparam int WB_AW = 4;
  localparam logic [WB_AW-1:0] ADR_PHASE = 4'h0;
  localparam logic [WB_AW-1:0] ADR_CTRL = 4'h4;
  localparam logic [WB_AW-1:0] ADR_STATUS = 4'h8;
  localparam logic [WB_AW-1:0] ADR_SEC_WORD = 4'hC;

  // =====================================================================
  // reset values and field positions
  localparam logic [PHASE_W-1:0] PHASE_RST = 8'h00;
  localparam logic CTRL_EN_RST = 1'b0;
  localparam int CTRL_EN_BIT = 0;
  localparam int ST_PEND_DIR = 0;
  localparam int ST_PEND_SEC = 3;
  localparam int ST_APP_DIR = 4;
  localparam int ST_APP_SEC = 7;
  localparam int ST_EMPTY = 8;
  localparam int ST_FULL = 9;
  localparam int ST_CTRL_BITS = 10;
  localparam int ST_PINS = 12;

  // =====================================================================
  // phase command
  typedef enum logic [2:0] {
    DIR_NONE = 3'b001,
    DIR_LATER = 3'b010,
    DIR_EARLIER = 3'b100
  } fcd_dir_t;

endpackage

// file: rtl/fcd_top.sv
// fcd_top: frame-sync serial port with primary control decode and phase shift
// assumes: pins and serial input synchronous to clk_i; wishbone classic master

// Operation
// R1: each frame moves 14 dac, 16 adc bits
// R2: bits 01 delay next sample by phase
// R3: negative phase on later moves frame earlier
// R4: bits 10 advance next sample by phase
// R5: negative phase on earlier moves frame later
// R6: pins 11 or bits 11 add secondary word
// R7: secondary sync half a period after primary
// R8: bits 11 pins 01: secondary plus later
// R9: bits 11 pins 10: secondary plus pin shift
// R10: bits 00 pins 10 advance by phase
// R11: unlisted bit and pin combinations are ignored; the code still delays on bits 00 pins 01
// R12: decode sampled once per frame, applied next
module fcd_top (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [fcd_pkg::WB_AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // serial link
  output logic frame_sync_n_o,
  output logic dout_o,
  input wire logic din_i,
  input wire logic func_ctrl_pin_hi_i,
  input wire logic func_ctrl_pin_lo_i,
  // adc sample stream
  input wire logic [fcd_pkg::WORD_W-1:0] adc_data_i,
  input wire logic adc_valid_i,
  output logic adc_ready_o,
  // dac sample stream
  output logic [fcd_pkg::DAC_W-1:0] dac_data_o,
  output logic dac_valid_o
);
  import fcd_pkg::*;

  // =====================================================================
  // state
  logic en_reg, shift_act_reg, shift_sec_reg, pend_sec_reg, app_sec_reg;
  logic fs_n_reg, dout_reg, dac_valid_reg, wb_ack_reg;
  logic [PHASE_W-1:0] phase_reg;
  logic [WORD_W-1:0] sec_word_reg, rx_reg, tx_reg;
  logic [CNT_W-1:0] cnt_reg, frame_len_reg;
  logic [1:0] div_reg, last_bits_reg, last_pins_reg;
  logic [3:0] bits_reg;
  fcd_dir_t pend_dir_reg, app_dir_reg;
  logic [DAC_W-1:0] dac_data_reg;
  logic [31:0] wb_dat_reg;

  logic frame_end, fs_rise_pt, sync_win, start_prim, start_sec, word_done, prim_done;
  logic [1:0] pins;
  logic [WORD_W-1:0] fifo_data;
  logic fifo_valid, fifo_empty, fifo_full, wb_req;
  logic [31:0] status_word;

  // =====================================================================
  // decode of control bits and pins
  function automatic fcd_dir_t decode_dir(input logic [1:0] cb, input logic [1:0] pn);
    case ({cb, pn})
      4'h1, 4'h4, 4'h7, 4'hD: return DIR_LATER;
      4'h2, 4'h8, 4'hB, 4'hE: return DIR_EARLIER;
      default: return DIR_NONE;
    endcase
  endfunction

  function automatic logic decode_sec(input logic [1:0] cb, input logic [1:0] pn);
    return (cb == 2'h3) || (pn == 2'h3);
  endfunction

  // signed phase count added to or taken from the base frame
  function automatic logic [CNT_W-1:0] calc_len(input fcd_dir_t dir,
                                                input logic [PHASE_W-1:0] ph);
    logic signed [CNT_W:0] base;
    logic signed [CNT_W:0] adj;
    base = $signed({1'b0, BASE_FRAME});
    adj = $signed({{(CNT_W + 1 - PHASE_W){ph[PHASE_W-1]}}, ph});
    case (dir)
      DIR_LATER: return CNT_W'(base + adj);
      DIR_EARLIER: return CNT_W'(base - adj);
      default: return BASE_FRAME;
    endcase
  endfunction

  assign pins = {func_ctrl_pin_hi_i, func_ctrl_pin_lo_i};

  // =====================================================================
  // frame counter and sync windows
  assign frame_end = en_reg && (cnt_reg == CNT_W'(frame_len_reg - 1'b1));
  assign fs_rise_pt = en_reg && (cnt_reg == SYNC_CYC);
  assign start_prim = en_reg && (cnt_reg == CNT_W'(SYNC_CYC - 1'b1));
  assign start_sec = en_reg && app_sec_reg && (cnt_reg == CNT_W'(SEC_POS + SYNC_CYC - 1'b1));
  assign sync_win = en_reg && ((cnt_reg < SYNC_CYC) ||
                    (app_sec_reg && (cnt_reg >= SEC_POS) &&
                     (cnt_reg < CNT_W'(SEC_POS + SYNC_CYC))));  // see R7
  assign word_done = shift_act_reg && (div_reg == DIV_LAST) && (bits_reg == LAST_BIT);
  assign prim_done = word_done && !shift_sec_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i || !en_reg) begin
      cnt_reg <= '0;
    end else if (frame_end) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  // shift applies from the rising sync edge of the frame after the command
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      frame_len_reg <= BASE_FRAME;
    end else if (fs_rise_pt) begin
      frame_len_reg <= calc_len(app_dir_reg, phase_reg);  // see R2 see R3 see R4 see R5 see R10
    end
  end

  // =====================================================================
  // command capture and application
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_dir_reg <= DIR_NONE;
      pend_sec_reg <= 1'b0;
      last_bits_reg <= 2'h0;
      last_pins_reg <= 2'h0;
    end else if (prim_done) begin
      pend_dir_reg <= decode_dir(rx_reg[1:0], pins);  // see R8 see R9 see R11 see R12
      pend_sec_reg <= decode_sec(rx_reg[1:0], pins);  // see R6
      last_bits_reg <= rx_reg[1:0];
      last_pins_reg <= pins;
    end else if (frame_end) begin
      pend_dir_reg <= DIR_NONE;
      pend_sec_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !en_reg) begin
      app_dir_reg <= DIR_NONE;
      app_sec_reg <= 1'b0;
    end else if (frame_end) begin
      app_dir_reg <= pend_dir_reg;  // see R12
      app_sec_reg <= pend_sec_reg;
    end
  end

  // =====================================================================
  // serial shift engine, four clocks per bit, msb first
  always_ff @(posedge clk_i) begin
    if (rst_i || !en_reg) begin
      shift_act_reg <= 1'b0;
      shift_sec_reg <= 1'b0;
      div_reg <= 2'h0;
      bits_reg <= 4'h0;
    end else if (start_prim || start_sec) begin
      shift_act_reg <= 1'b1;
      shift_sec_reg <= start_sec;
      div_reg <= 2'h0;
      bits_reg <= 4'h0;
    end else if (shift_act_reg) begin
      div_reg <= div_reg + 1'b1;
      if (div_reg == DIV_LAST) begin
        bits_reg <= bits_reg + 1'b1;
      end
      if (word_done) begin
        shift_act_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_reg <= '0;
    end else if (start_prim) begin
      tx_reg <= fifo_valid ? fifo_data : '0;  // see R1
    end else if (start_sec) begin
      tx_reg <= '0;
    end else if (shift_act_reg && (div_reg == DIV_LAST)) begin
      tx_reg <= {tx_reg[WORD_W-2:0], 1'b0};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_reg <= '0;
    end else if (shift_act_reg && (div_reg == DIV_SAMPLE)) begin
      rx_reg <= {rx_reg[WORD_W-2:0], din_i};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fs_n_reg <= 1'b1;
      dout_reg <= 1'b0;
    end else begin
      fs_n_reg <= !sync_win;
      dout_reg <= shift_act_reg && !shift_sec_reg && tx_reg[WORD_W-1];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dac_data_reg <= '0;
      dac_valid_reg <= 1'b0;
    end else begin
      dac_valid_reg <= prim_done;
      if (prim_done) begin
        dac_data_reg <= rx_reg[WORD_W-1:2];  // see R1
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sec_word_reg <= '0;
    end else if (word_done && shift_sec_reg) begin
      sec_word_reg <= rx_reg;  // see R6
    end
  end

  // =====================================================================
  // adc sample buffer, drained once per primary frame
  fcd_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_data_i(adc_data_i),
    .in_valid_i(adc_valid_i),
    .in_ready_o(adc_ready_o),
    .out_data_o(fifo_data),
    .out_valid_o(fifo_valid),
    .out_ready_i(start_prim),
    .empty_o(fifo_empty),
    .full_o(fifo_full)
  );

  // =====================================================================
  // wishbone slave
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_reg;

  always_comb begin
    status_word = '0;
    status_word[ST_PEND_DIR +: 3] = pend_dir_reg;
    status_word[ST_PEND_SEC] = pend_sec_reg;
    status_word[ST_APP_DIR +: 3] = app_dir_reg;
    status_word[ST_APP_SEC] = app_sec_reg;
    status_word[ST_EMPTY] = fifo_empty;
    status_word[ST_FULL] = fifo_full;
    status_word[ST_CTRL_BITS +: 2] = last_bits_reg;
    status_word[ST_PINS +: 2] = last_pins_reg;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_reg <= 1'b0;
      wb_dat_reg <= '0;
    end else begin
      wb_ack_reg <= wb_req;
      if (wb_req && !wb_we_i) begin
        if (wb_adr_i == ADR_PHASE) begin
          wb_dat_reg <= {24'h000000, phase_reg};
        end else if (wb_adr_i == ADR_CTRL) begin
          wb_dat_reg <= {31'h00000000, en_reg};
        end else if (wb_adr_i == ADR_STATUS) begin
          wb_dat_reg <= status_word;
        end else if (wb_adr_i == ADR_SEC_WORD) begin
          wb_dat_reg <= {16'h0000, sec_word_reg};
        end else begin
          wb_dat_reg <= '0;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_reg <= PHASE_RST;
      en_reg <= CTRL_EN_RST;
    end else if (wb_req && wb_we_i && wb_sel_i[0]) begin
      if (wb_adr_i == ADR_PHASE) begin
        phase_reg <= wb_dat_i[PHASE_W-1:0];
      end else if (wb_adr_i == ADR_CTRL) begin
        en_reg <= wb_dat_i[CTRL_EN_BIT];
      end
    end
  end

  assign wb_ack_o = wb_ack_reg;
  assign wb_dat_o = wb_dat_reg;
  assign frame_sync_n_o = fs_n_reg;
  assign dout_o = dout_reg;
  assign dac_data_o = dac_data_reg;
  assign dac_valid_o = dac_valid_reg;

  // =====================================================================
  // checks
  logic [CNT_W:0] per_cnt_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i || !en_reg || frame_end) begin
      per_cnt_reg <= '0;
    end else begin
      per_cnt_reg <= per_cnt_reg + 1'b1;
    end
  end

  default clocking cb_main @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_word_length: assert property ($rose(frame_sync_n_o) |-> ##62 word_done)  // see R1
    else $error("serial word did not end 16 bits after sync");
  a_dac_taken: assert property (prim_done |=> dac_valid_o && dac_data_o == $past(rx_reg[15:2]))  // see R1
    else $error("dac word not delivered after primary word");
  a_later_len: assert property (frame_end && app_dir_reg == DIR_LATER && $stable(phase_reg)  // see R2
    |-> int'(per_cnt_reg) + 1 == int'(BASE_FRAME) + int'($signed(phase_reg)))
    else $error("later frame length wrong");
  a_earlier_len: assert property (frame_end && app_dir_reg == DIR_EARLIER && $stable(phase_reg)  // see R4
    |-> int'(per_cnt_reg) + 1 == int'(BASE_FRAME) - int'($signed(phase_reg)))
    else $error("earlier frame length wrong");
  a_plain_len: assert property (frame_end && app_dir_reg == DIR_NONE  // see R11
    |-> per_cnt_reg + 1'b1 == (CNT_W + 1)'(BASE_FRAME))
    else $error("unshifted frame length wrong");
  a_sec_sync: assert property (en_reg && cnt_reg == '0 && app_sec_reg  // see R7
    |-> ##257 $fell(frame_sync_n_o) ##4 frame_sync_n_o)
    else $error("secondary sync not at half period");
  a_no_sec_sync: assert property (en_reg && cnt_reg == SEC_POS && !app_sec_reg  // see R6
    |=> frame_sync_n_o [*4])
    else $error("secondary sync without command");
  a_sec_pins: assert property (prim_done && pins == 2'h3 |=> pend_sec_reg)  // see R6
    else $error("pins high did not request secondary word");
  a_r8_decode: assert property (prim_done && rx_reg[1:0] == 2'h3 && pins == 2'h1  // see R8
    |=> pend_sec_reg && pend_dir_reg == DIR_LATER)
    else $error("bits 11 pins 01 decoded wrong");
  a_r9_decode: assert property (prim_done && rx_reg[1:0] == 2'h3 && pins == 2'h2  // see R9
    |=> pend_sec_reg && pend_dir_reg == DIR_EARLIER)
    else $error("bits 11 pins 10 decoded wrong");
  a_r10_decode: assert property (prim_done && rx_reg[1:0] == 2'h0 && pins == 2'h2  // see R10
    |=> !pend_sec_reg && pend_dir_reg == DIR_EARLIER)
    else $error("bits 00 pins 10 decoded wrong");
  a_ignored: assert property (prim_done && (rx_reg[1:0] == 2'h1 || rx_reg[1:0] == 2'h2)  // see R11
    && (pins == 2'h1 || pins == 2'h2) |=> !pend_sec_reg && pend_dir_reg == DIR_NONE)
    else $error("unlisted combination not ignored");
  a_next_frame: assert property (frame_end |=> app_dir_reg == $past(pend_dir_reg)  // see R12
    && app_sec_reg == $past(pend_sec_reg))
    else $error("command not applied at next frame");

  c_later: cover property (frame_end && app_dir_reg == DIR_LATER);
  c_earlier: cover property (frame_end && app_dir_reg == DIR_EARLIER);
  c_sec_word: cover property (word_done && shift_sec_reg);
  c_fifo_full: cover property (fifo_full && adc_valid_i);

endmodule

// file: tb/fcd_host_model.sv
// fcd_host_model: host serial port facing the frame control decoder
// assumes: device drives frame sync; bench supplies one word per sync
module fcd_host_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // serial link
  input wire logic frame_sync_n_i,
  input wire logic dout_i,
  output logic din_o,
  // bench side
  input wire logic [15:0] prim_word_i,
  input wire logic [15:0] sec_word_i,
  output logic fall_o,
  output logic is_sec_o,
  output logic [15:0] gap_o,
  output logic done_o,
  output logic [15:0] adc_word_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic fs_reg;
  logic sec_reg;
  logic [6:0] k_reg;
  logic [15:0] since_reg;
  logic [15:0] sh_reg;
  logic [15:0] rx_reg;

  // =====================================================================
  // sync spacing, word shift out and capture
  always_ff @(posedge clk_i) begin
    fs_reg <= frame_sync_n_i;
    fall_o <= 1'b0;
    done_o <= 1'b0;
    since_reg <= since_reg + 16'h0001;
    if (k_reg != 7'h7F) begin
      k_reg <= k_reg + 7'h01;
    end
    // bit held over four cycles around the sampling edge, toggling when idle
    if (k_reg >= 7'h03 && k_reg <= 7'h42) begin
      if (k_reg[1:0] == 2'h3) begin
        din_o <= sh_reg[15];
        sh_reg <= {sh_reg[14:0], 1'b0};
      end
    end else begin
      din_o <= ~din_o;
    end
    if (k_reg[1:0] == 2'h1 && k_reg >= 7'h05 && k_reg <= 7'h41) begin
      rx_reg <= {rx_reg[14:0], dout_i};
    end
    if (k_reg == 7'h42 && !sec_reg) begin
      done_o <= 1'b1;
      adc_word_o <= rx_reg;
    end
    if (rst_i) begin
      fs_reg <= 1'b1;
      k_reg <= 7'h7F;
      since_reg <= 16'h0000;
      din_o <= 1'b0;
      fall_o <= 1'b0;
      done_o <= 1'b0;
    end else if (fs_reg && !frame_sync_n_i) begin
      fall_o <= 1'b1;
      is_sec_o <= (since_reg == 16'h0100);
      sec_reg <= (since_reg == 16'h0100);
      gap_o <= since_reg;
      k_reg <= 7'h01;
      sh_reg <= (since_reg == 16'h0100) ? sec_word_i : prim_word_i;
      if (since_reg != 16'h0100) begin
        since_reg <= 16'h0001;
      end
    end
  end
endmodule

// file: tb/testbench.sv
// testbench: frame control decoder against the host model, wishbone master
// assumes: 25 mhz clock, synchronous reset held 16 cycles
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import fcd_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [WB_AW-1:0] wb_adr = 4'h0;
  logic [3:0] wb_sel = 4'hF;
  logic [31:0] wb_wdat = 32'h0;
  logic [31:0] wb_rdat;
  logic wb_ack;
  logic fs_n, dout, din, dac_valid, adc_ready, fall_e, is_sec, done_e;
  logic pin_hi = 1'b0;
  logic pin_lo = 1'b0;
  logic [15:0] adc_data = 16'h0;
  logic adc_valid = 1'b0;
  logic [13:0] dac_data;
  logic [15:0] prim_word = 16'h0;
  logic [15:0] sec_word = 16'h0;
  logic [15:0] sent = 16'h0;
  logic [15:0] gap, adc_word;
  logic [15:0] adc_q[$];
  logic [31:0] xs = 32'h91FA0987;
  int error_cnt = 0;
  int checked = 0;
  int sec_cnt = 0;

  always #20 clk_i = ~clk_i;

  fcd_top fcd_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .frame_sync_n_o(fs_n), .dout_o(dout),
    .din_i(din), .func_ctrl_pin_hi_i(pin_hi), .func_ctrl_pin_lo_i(pin_lo),
    .adc_data_i(adc_data), .adc_valid_i(adc_valid), .adc_ready_o(adc_ready),
    .dac_data_o(dac_data), .dac_valid_o(dac_valid));

  fcd_host_model fcd_host_model_i (.clk_i(clk_i), .rst_i(rst_i), .frame_sync_n_i(fs_n),
    .dout_i(dout), .din_o(din), .prim_word_i(prim_word), .sec_word_i(sec_word),
    .fall_o(fall_e), .is_sec_o(is_sec), .gap_o(gap), .done_o(done_e), .adc_word_o(adc_word));

  // =====================================================================
  // helpers
  function automatic logic [31:0] rnd();
    xs = xs ^ (xs << 13);
    xs = xs ^ (xs >> 17);
    xs = xs ^ (xs << 5);
    return xs;
  endfunction

  function automatic logic [15:0] exp_len(input logic [3:0] c, input logic [7:0] ph);
    logic [15:0] p;
    p = {{8{ph[7]}}, ph};
    case (c)
      4'h1, 4'h4, 4'h7, 4'hD: return 16'h0200 + p;
      4'h2, 4'h8, 4'hB, 4'hE: return 16'h0200 - p;
      default: return 16'h0200;
    endcase
  endfunction

  task automatic report_and_stop();
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD word t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_count(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD count t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic we, input logic [3:0] adr, input logic [3:0] sel,
                    input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_sel <= sel;
    wb_wdat <= wd;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    if (wb_ack !== 1'b1) begin
      error_cnt++;
      report_and_stop();
    end
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wait_prim();
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (!(fall_e === 1'b1 && is_sec === 1'b0) && n < 2000);
    if (n >= 2000) begin
      error_cnt++;
      report_and_stop();
    end
  endtask

  // =====================================================================
  // stream monitor
  always @(posedge clk_i) begin
    if (fall_e === 1'b1 && is_sec === 1'b1) sec_cnt++;
    if (fall_e === 1'b1 && is_sec === 1'b0) sent <= prim_word;
    if (dac_valid === 1'b1) chk_word({2'b00, dac_data}, {2'b00, sent[15:2]});
    if (done_e === 1'b1) chk_word(adc_word, adc_q.size() > 0 ? adc_q.pop_front() : 16'h0);
  end

  // =====================================================================
  // main sequence
  initial begin
    logic [31:0] rd;
    logic [3:0] c;
    logic [7:0] ph;
    logic es;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, ADR_PHASE, 4'hF, 32'h0, rd);
    chk_word(rd[15:0], {8'h00, PHASE_RST});
    wb(1'b0, ADR_CTRL, 4'hF, 32'h0, rd);
    chk_word(rd[15:0], 16'h0000);
    wb(1'b1, ADR_PHASE, 4'hE, 32'h55, rd);
    wb(1'b0, ADR_PHASE, 4'hF, 32'h0, rd);
    chk_word(rd[15:0], {8'h00, PHASE_RST});
    wb(1'b1, 4'h2, 4'hF, 32'hFF, rd);
    wb(1'b0, 4'h2, 4'hF, 32'h0, rd);
    chk_word(rd[15:0], 16'h0000);
    for (int i = 0; i < 9; i++) begin
      adc_data <= 16'(rnd());
      adc_valid <= 1'b1;
      @(posedge clk_i);
      if (i < 8) adc_q.push_back(adc_data);
    end
    adc_valid <= 1'b0;
    chk_word({15'h0, adc_ready}, 16'h0000);
    wb(1'b0, ADR_STATUS, 4'hF, 32'h0, rd);
    chk_word({14'h0, rd[ST_FULL], rd[ST_EMPTY]}, 16'h0002);
    wb(1'b1, ADR_CTRL, 4'hF, 32'h1, rd);
    for (int t = 0; t < 20; t++) begin
      wait_prim();
      c = (t < 16) ? t[3:0] : 4'(rnd());
      ph = 8'(int'(rnd() % 100) + 1);
      if (t % 2 == 1) ph = -ph;
      es = (c[3:2] == 2'h3) || (c[1:0] == 2'h3);
      prim_word <= {14'(rnd()), c[3:2]};
      pin_hi <= c[1];
      pin_lo <= c[0];
      sec_word <= 16'(rnd());
      wb(1'b1, ADR_PHASE, 4'hF, {24'h0, ph}, rd);
      wait_prim();
      prim_word <= {14'(rnd()), 2'b00};
      repeat (100) @(posedge clk_i);
      pin_hi <= 1'b0;
      pin_lo <= 1'b0;
      wait_prim();
      sec_cnt = 0;
      wait_prim();
      chk_count(gap, exp_len(c, ph));
      chk_count(16'(sec_cnt), {15'h0, es});
      if (es) begin
        wb(1'b0, ADR_SEC_WORD, 4'hF, 32'h0, rd);
        chk_word(rd[15:0], sec_word);
      end
    end
    report_and_stop();
  end
endmodule
